// *** design/sowu_pkg.sv ***
package sowu_pkg;
   localparam logic [11:0] SOWU_ADDR_OPTIONS = 12'h000;
   localparam logic [11:0] SOWU_ADDR_CLKOUT = 12'h004;
   localparam logic [11:0] SOWU_ADDR_PART_HIGH = 12'h008;
   localparam logic [11:0] SOWU_ADDR_PART_LOW = 12'h00c;
   localparam logic [11:0] SOWU_ADDR_WAKEUP = 12'h010;
   localparam int SOWU_OPT_WDOG_EN = 7;
   localparam int SOWU_OPT_WDOG_LONG = 6;
   localparam int SOWU_OPT_STOP_EN = 5;
   localparam logic [7:0] SOWU_OPT_RESET = 8'hc0;
   localparam logic [7:0] SOWU_OPT_MASK = 8'he3;
   localparam int SOWU_CLK_PIN_EN = 4;
   localparam logic [7:0] SOWU_CLK_MASK = 8'h17;
   localparam logic [7:0] SOWU_CLK_RESET = 8'h00;
   localparam int SOWU_WK_FLAG = 7;
   localparam int SOWU_WK_ACK = 6;
   localparam int SOWU_WK_CLKSEL = 5;
   localparam int SOWU_WK_IEN = 4;
   localparam logic [7:0] SOWU_WK_MASK = 8'h37;
   localparam logic [7:0] SOWU_WK_RESET = 8'h00;
   // internal oscillator period 1 ms; delays in ms
   localparam int SOWU_INT_TICK_MS = 1;
   // wakeup delays per delay select code 1..7
   localparam int SOWU_INT_MS_1 = 8;
   localparam int SOWU_INT_MS_2 = 32;
   localparam int SOWU_INT_MS_3 = 64;
   localparam int SOWU_INT_MS_4 = 128;
   localparam int SOWU_INT_MS_5 = 256;
   localparam int SOWU_INT_MS_6 = 512;
   localparam int SOWU_INT_MS_7 = 1024;
   localparam int SOWU_EXT_DIV_1 = 256;
   localparam int SOWU_EXT_DIV_2 = 1024;
   localparam int SOWU_EXT_DIV_3 = 2048;
   localparam int SOWU_EXT_DIV_4 = 4096;
   localparam int SOWU_EXT_DIV_5 = 8192;
   localparam int SOWU_EXT_DIV_6 = 16384;
   localparam int SOWU_EXT_DIV_7 = 32768;
   // count widths fit the longest delay of 32768 source ticks
   localparam int SOWU_CNT_W = 16;
endpackage : sowu_pkg

// *** design/sowu_top.sv ***
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sowu_top #(
   parameter logic [11:0] PART_NUMBER = 12'h5a3 // arbitrary value
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_1khz_tick,
   input wire logic xtal_tick,
   input wire logic stop_attempt,
   input wire logic watchdog_timeout,
   output logic watchdog_enable,
   output logic watchdog_long_timeout,
   output logic stop_mode_enable,
   output logic stop_granted,
   output logic illegal_opcode_reset,
   output logic watchdog_reset,
   output logic clock_output_pin,
   output logic clock_output_pin_oe,
   output logic wakeup_irq
);
   import sowu_pkg::*;

   logic [7:0] system_options;
   logic options_written;
   logic [7:0] clock_output_control;
   logic [7:0] wakeup_timer_status_control;
   logic [2:0] div_cnt;
   logic [SOWU_CNT_W-1:0] tick_cnt;
   logic [SOWU_CNT_W-1:0] int_limit [8];
   logic [SOWU_CNT_W-1:0] ext_limit [8];

   wire access = psel & penable;
   wire wr = access & pwrite;
   wire sel_opt = (paddr == SOWU_ADDR_OPTIONS);
   wire sel_clk = (paddr == SOWU_ADDR_CLKOUT);
   wire sel_part_high = (paddr == SOWU_ADDR_PART_HIGH);
   wire sel_part_low = (paddr == SOWU_ADDR_PART_LOW);
   wire sel_wk = (paddr == SOWU_ADDR_WAKEUP);
   wire wr_opt = wr & sel_opt;
   wire wr_clk = wr & sel_clk;
   wire wr_wk = wr & sel_wk;
   wire hit = sel_opt | sel_clk | sel_part_high | sel_part_low | sel_wk;
   wire [2:0] div_sel = clock_output_control[2:0];
   wire [2:0] delay_sel = wakeup_timer_status_control[2:0];
   wire wk_clksel = wakeup_timer_status_control[SOWU_WK_CLKSEL];
   wire src_tick = wk_clksel ? xtal_tick : osc_1khz_tick;
   wire timer_on = (delay_sel != 3'h0);
   wire [SOWU_CNT_W-1:0] limit = wk_clksel ? ext_limit[delay_sel] :
      int_limit[delay_sel];
   wire timeout = timer_on & src_tick & (tick_cnt == limit - 1'b1);
   wire ack = wr_wk & pwdata[SOWU_WK_ACK];

   // delay in source ticks; entry 0 unused, timer is off there
   assign int_limit[0] = '0;
   assign int_limit[1] = SOWU_CNT_W'(SOWU_INT_MS_1 / SOWU_INT_TICK_MS);
   assign int_limit[2] = SOWU_CNT_W'(SOWU_INT_MS_2 / SOWU_INT_TICK_MS);
   assign int_limit[3] = SOWU_CNT_W'(SOWU_INT_MS_3 / SOWU_INT_TICK_MS);
   assign int_limit[4] = SOWU_CNT_W'(SOWU_INT_MS_4 / SOWU_INT_TICK_MS);
   assign int_limit[5] = SOWU_CNT_W'(SOWU_INT_MS_5 / SOWU_INT_TICK_MS);
   assign int_limit[6] = SOWU_CNT_W'(SOWU_INT_MS_6 / SOWU_INT_TICK_MS);
   assign int_limit[7] = SOWU_CNT_W'(SOWU_INT_MS_7 / SOWU_INT_TICK_MS);
   assign ext_limit[0] = '0;
   assign ext_limit[1] = SOWU_CNT_W'(SOWU_EXT_DIV_1);
   assign ext_limit[2] = SOWU_CNT_W'(SOWU_EXT_DIV_2);
   assign ext_limit[3] = SOWU_CNT_W'(SOWU_EXT_DIV_3);
   assign ext_limit[4] = SOWU_CNT_W'(SOWU_EXT_DIV_4);
   assign ext_limit[5] = SOWU_CNT_W'(SOWU_EXT_DIV_5);
   assign ext_limit[6] = SOWU_CNT_W'(SOWU_EXT_DIV_6);
   assign ext_limit[7] = SOWU_CNT_W'(SOWU_EXT_DIV_7);

   // read data, reads have no side effects
   wire [7:0] rd_byte = sel_opt ? (system_options & SOWU_OPT_MASK) :
      sel_clk ? (clock_output_control & SOWU_CLK_MASK) :
      sel_part_high ? {4'h0, PART_NUMBER[11:8]} :
      sel_part_low ? PART_NUMBER[7:0] :
      sel_wk ? wakeup_timer_status_control :
      8'h00;

   assign pready = 1'b1;
   assign pslverr = access & ~hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= {24'h000000, rd_byte};
      end
   end

   // write-once guard against runaway code changing watchdog settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_options <= SOWU_OPT_RESET;
         options_written <= 1'b0;
      end else if (wr_opt && !options_written) begin
         system_options <= pwdata[7:0] & SOWU_OPT_MASK;
         options_written <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_output_control <= SOWU_CLK_RESET;
      end else if (wr_clk) begin
         clock_output_control <= pwdata[7:0] & SOWU_CLK_MASK;
      end
   end

   // half period is div_sel bus cycles, so full period is 2*div_sel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 3'h0;
         clock_output_pin <= 1'b0;
      end else if (div_sel == 3'h0) begin
         div_cnt <= 3'h0;
         clock_output_pin <= 1'b0;
      end else if (div_cnt >= div_sel - 3'h1) begin
         div_cnt <= 3'h0;
         clock_output_pin <= ~clock_output_pin;
      end else begin
         div_cnt <= div_cnt + 3'h1;
      end
   end
   assign clock_output_pin_oe = clock_output_control[SOWU_CLK_PIN_EN];

   // set wins over the acknowledge in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wakeup_timer_status_control <= SOWU_WK_RESET;
      end else begin
         if (wr_wk) begin
            wakeup_timer_status_control[5:0] <= pwdata[5:0] & SOWU_WK_MASK[5:0];
         end
         if (timeout) begin
            wakeup_timer_status_control[SOWU_WK_FLAG] <= 1'b1;
         end else if (ack) begin
            wakeup_timer_status_control[SOWU_WK_FLAG] <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
      end else if (!timer_on) begin
         tick_cnt <= '0;
      end else if (timeout) begin
         tick_cnt <= '0;
      end else if (src_tick) begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end

   assign wakeup_irq = wakeup_timer_status_control[SOWU_WK_FLAG] &
      wakeup_timer_status_control[SOWU_WK_IEN];
   assign watchdog_enable = system_options[SOWU_OPT_WDOG_EN];
   assign watchdog_long_timeout = system_options[SOWU_OPT_WDOG_LONG];
   assign stop_mode_enable = system_options[SOWU_OPT_STOP_EN];
   assign stop_granted = stop_attempt & stop_mode_enable;
   assign illegal_opcode_reset = stop_attempt & ~stop_mode_enable;
   assign watchdog_reset = watchdog_timeout & watchdog_enable;
endmodule // sowu_top
`default_nettype wire

// *** test/sowu_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sowu_top_monitor
   import sowu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic stop_attempt,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic watchdog_timeout,
   input wire logic watchdog_enable,
   input wire logic stop_mode_enable,
   input wire logic watchdog_long_timeout,
   input wire logic stop_granted,
   input wire logic watchdog_reset,
   input wire logic illegal_opcode_reset
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic done;
   wire logic acc = psel && penable && paddr == SOWU_ADDR_OPTIONS;
   wire logic [2:0] opt =
      {watchdog_enable, watchdog_long_timeout, stop_mode_enable};
   // set by writes only, so reads never use up the single write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done <= 1'b0;
      end else if (acc && pwrite) begin
         done <= 1'b1;
      end
   end
   property p_once; done && acc && pwrite |=> $stable(opt); endproperty
   a_once: assert property (p_once) else $error("options rewritten");
   property p_rst; $rose(presetn) |-> opt == 3'h6; endproperty
   a_rst: assert property (p_rst) else $error("options reset");
   property p_read; acc && !pwrite |-> prdata[7:5] == opt; endproperty
   a_read: assert property (p_read) else $error("options read");
   property p_zero; acc && !pwrite |-> prdata[3:2] == 2'h0; endproperty
   a_zero: assert property (p_zero) else $error("options bits 3:2");
   property p_ilop; stop_attempt |-> illegal_opcode_reset != opt[0]; endproperty
   a_ilop: assert property (p_ilop) else $error("illegal stop");
   property p_grant; stop_attempt |-> stop_granted == opt[0]; endproperty
   a_grant: assert property (p_grant) else $error("stop grant");
   property p_wdoff; !opt[2] |-> !watchdog_reset; endproperty
   a_wdoff: assert property (p_wdoff) else $error("watchdog off");
   property p_wdon; watchdog_timeout && opt[2] |-> watchdog_reset; endproperty
   a_wdon: assert property (p_wdon) else $error("watchdog on");
endmodule // sowu_top_monitor
bind sowu_top sowu_top_monitor i_mon (.*);
`default_nettype wire

// *** test/system_options_and_periodic_wakeup_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module system_options_and_periodic_wakeup_bench;
   import sowu_pkg::*;
   localparam logic [11:0] PN = 12'h2d7; // arbitrary value
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic osc_1khz_tick = 0, xtal_tick = 0, stop_attempt = 0, pready, pslverr;
   logic watchdog_timeout = 0, watchdog_enable, watchdog_long_timeout;
   logic stop_mode_enable, stop_granted, illegal_opcode_reset, wakeup_irq;
   logic watchdog_reset, clock_output_pin, clock_output_pin_oe;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   int errors = 0, checks_done = 0, cyc = 0;
   time t0;
   logic last_err;
   sowu_top #(
      .PART_NUMBER(PN)
   ) i_dut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .osc_1khz_tick(osc_1khz_tick),
      .xtal_tick(xtal_tick),
      .stop_attempt(stop_attempt),
      .watchdog_timeout(watchdog_timeout),
      .watchdog_enable(watchdog_enable),
      .watchdog_long_timeout(watchdog_long_timeout),
      .stop_mode_enable(stop_mode_enable),
      .stop_granted(stop_granted),
      .illegal_opcode_reset(illegal_opcode_reset),
      .watchdog_reset(watchdog_reset),
      .clock_output_pin(clock_output_pin),
      .clock_output_pin_oe(clock_output_pin_oe),
      .wakeup_irq(wakeup_irq)
   );
   always #5 pclk = ~pclk;
   task automatic chk(input logic [31:0] s, e);
      checks_done++;
      if (s !== e) errors++;
      if (s !== e) $display("[ERR] %0t got %h want %h", $time, s, e);
   endtask
   task automatic acc(input logic w, logic [11:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      // no local limit; the cycle ceiling ends a hung wait
      do @(posedge pclk); while (pready !== 1'b1);
      last_err = pslverr;
      if (!w) chk(prdata, d);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic tick(input logic x, int k);
      repeat (k) begin
         {osc_1khz_tick, xtal_tick} <= {1'b1, x};
         @(posedge pclk) {osc_1khz_tick, xtal_tick} <= 2'h0;
         @(posedge pclk);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ceiling well above the ~650 cycles the sequence needs
   always @(posedge pclk) if (++cyc == 5000) begin errors++; complete_run(); end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      acc(0, SOWU_ADDR_OPTIONS, 32'hc0);
      chk(last_err, 1'b0);
      acc(0, 12'h014, 32'h0);
      chk(last_err, 1'b1);
      acc(0, SOWU_ADDR_PART_HIGH, 32'(PN[11:8]));
      acc(1, SOWU_ADDR_PART_HIGH, 32'hff);
      acc(0, SOWU_ADDR_PART_HIGH, 32'(PN[11:8]));
      acc(0, SOWU_ADDR_PART_LOW, 32'(PN[7:0]));
      {stop_attempt, watchdog_timeout} <= 2'h3;
      acc(1, SOWU_ADDR_OPTIONS, 32'h2c);
      acc(1, SOWU_ADDR_OPTIONS, 32'hff);
      acc(0, SOWU_ADDR_OPTIONS, 32'h20);
      {stop_attempt, watchdog_timeout} <= 2'h0;
      acc(1, SOWU_ADDR_CLKOUT, 32'h13);
      @(posedge clock_output_pin) t0 = $time;
      @(posedge clock_output_pin) chk(32'($time - t0), 32'h3c);
      chk(clock_output_pin_oe, 1);
      acc(1, SOWU_ADDR_CLKOUT, 32'h10);
      repeat (8) @(posedge pclk) chk(clock_output_pin, 1'b0);
      acc(1, SOWU_ADDR_WAKEUP, 32'h11);
      tick(0, 7);
      chk(wakeup_irq, 0);
      tick(0, 1);
      chk(wakeup_irq, 1);
      acc(1, SOWU_ADDR_WAKEUP, 32'h71);
      tick(1, 255);
      acc(0, SOWU_ADDR_WAKEUP, 32'h31);
      tick(1, 1);
      acc(0, SOWU_ADDR_WAKEUP, 32'hb1);
      acc(1, SOWU_ADDR_WAKEUP, 32'h21);
      chk(wakeup_irq, 1'b0);
      acc(0, SOWU_ADDR_WAKEUP, 32'ha1);
      acc(1, SOWU_ADDR_WAKEUP, 32'h50);
      tick(1'b0, 10);
      acc(0, SOWU_ADDR_WAKEUP, 32'h10);
      chk(wakeup_irq, 1'b0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk(clock_output_pin_oe, 1'b0);
      acc(0, SOWU_ADDR_WAKEUP, 32'h00);
      acc(0, SOWU_ADDR_OPTIONS, 32'hc0);
      acc(1, SOWU_ADDR_OPTIONS, 32'h00);
      acc(0, SOWU_ADDR_OPTIONS, 32'h00);
      complete_run();
   end
endmodule // system_options_and_periodic_wakeup_bench
`default_nettype wire
